//--- rtl/fbiu_mem.sv
// Program page store: four 32-bit words with a registered read port
`timescale 1ns/1ps
module fbiu_mem (
	input wire logic clk_i,
	input wire logic nrst_i,
	fbiu_mem_if.mem bus
);
	fbiu_pkg::fbiu_mem_state_t st_reg;
	fbiu_pkg::fbiu_mem_state_t st_next;

	// Word write and registered read
	always_comb
	begin
		st_next = st_reg;
		if (bus.wr)
		begin
			st_next.word[bus.wr_idx] = bus.wr_data;
		end
		st_next.rd = st_reg.word[bus.rd_idx];
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Word 0 sits in the low bits of the page
	assign bus.page = st_reg.word;
	assign bus.rd_data = st_reg.rd;

endmodule : fbiu_mem

//--- rtl/fbiu_top.sv
// Flash bus interface unit: settings, page buffer and program/erase supervisor
// Function
// - Reset loads pipelining 0b111, read waits 0b111, write waits 0b11, enables 0, limit 0b00.
// - Reads work at any clock up to the maximum with no lower bound.
// - A program page is four 32-bit words, the small unit a 64-bit double word.
// - Programming a double word or page ends within 500 us.
// - Block erase ends within 5000 ms, or 15000 ms for 128 Kbyte blocks.
`timescale 1ns/1ps
`include "fbiu_cfg.svh"
module fbiu_top #(
	parameter logic [29:0] PROG_MAX_CYC =
		30'(`FBIU_PROG_MAX_US * (`FBIU_CLK_KHZ / 1000)),
	parameter logic [29:0] ERASE_MAX_CYC =
		30'(`FBIU_ERASE_MAX_MS * `FBIU_CLK_KHZ),
	parameter logic [29:0] ERASE128_MAX_CYC =
		30'(`FBIU_ERASE128_MAX_MS * `FBIU_CLK_KHZ)
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic [2:0] address_pipeline_control_o,
	output logic [2:0] read_wait_state_count_o,
	output logic [1:0] write_wait_state_count_o,
	output logic data_prefetch_enable_o,
	output logic instruction_prefetch_enable_o,
	output logic [1:0] prefetch_limit_o,
	output logic line_buffer_enable_o,
	output logic pipelined_read_disable_o,
	output logic fl_prog_o,
	output logic fl_erase_o,
	output logic fl_page_mode_o,
	output logic [1:0] fl_block_o,
	output logic [127:0] fl_data_o,
	input wire logic fl_done_i,
	output logic busy_o,
	output logic illegal_cfg_o
);
	localparam fbiu_pkg::fbiu_state_t ST_RST = '{
		pipe: `FBIU_PIPE_RST, rwait: `FBIU_RWAIT_RST, wwsc: `FBIU_WWSC_RST,
		dpf: 1'b0, ipf: 1'b0, pf_limit: `FBIU_PF_LIMIT_RST, lbuf: 1'b0,
		rd_dis: 1'b0, phase: fbiu_pkg::st_idle, page_mode: 1'b0, blk: 2'h0,
		cnt: 30'h0, done: 1'b0, tmo: 1'b0, rdata: 32'h0, rd_mem: 1'b0};

	fbiu_pkg::fbiu_state_t st_reg;
	fbiu_pkg::fbiu_state_t st_next;
	fbiu_mem_if mem_bus ();
	logic busy;
	logic legal;
	logic [29:0] cur_limit;

	// Settings taken from one row: equal pipelining and read waits, write waits 01
	function automatic logic row_ok(input logic [2:0] pipe, input logic [2:0] rwait,
		input logic [1:0] wwsc, input logic rd_dis);
		row_ok = (pipe == rwait) && (pipe <= `FBIU_ROW_MAX) && (wwsc == `FBIU_WWSC_ROW)
			&& ((pipe != 3'h0) || rd_dis);
	endfunction : row_ok

	// Worst case duration for the running operation
	function automatic logic [29:0] op_limit(input fbiu_pkg::fbiu_phase_t ph,
		input logic [1:0] blk);
		if (ph == fbiu_pkg::st_prog)
		begin
			op_limit = PROG_MAX_CYC;
		end
		else if (blk == `FBIU_BLK_128K)
		begin
			op_limit = ERASE128_MAX_CYC;
		end
		else
		begin
			op_limit = ERASE_MAX_CYC;
		end
	endfunction : op_limit

	fbiu_mem u_mem (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.bus(mem_bus.mem)
	);

	assign busy = (st_reg.phase != fbiu_pkg::st_idle);
	assign legal = row_ok(st_reg.pipe, st_reg.rwait, st_reg.wwsc, st_reg.rd_dis);
	assign cur_limit = op_limit(st_reg.phase, st_reg.blk);

	// Page words accepted only while idle, so the flash sees stable data
	assign mem_bus.wr = wr_i && !busy && (addr_i[7:4] == 4'(`FBIU_DATA_OFS >> 4));
	assign mem_bus.wr_idx = addr_i[3:2];
	assign mem_bus.wr_data = wdata_i;
	assign mem_bus.rd_idx = addr_i[3:2];

	// Next state: register writes, reads and the operation supervisor
	always_comb
	begin
		st_next = st_reg;
		st_next.rdata = 32'h0;
		st_next.rd_mem = 1'b0;
		st_next.cnt = st_reg.cnt + 30'h1;
		if (wr_i && addr_i == `FBIU_CFG_OFS)
		begin
			// Applied at once, whatever the clock rate
			st_next.pipe = wdata_i[`FBIU_PIPE_LSB +: 3];
			st_next.rwait = wdata_i[`FBIU_RWAIT_LSB +: 3];
			st_next.wwsc = wdata_i[`FBIU_WWSC_LSB +: 2];
			st_next.dpf = wdata_i[`FBIU_DPF_BIT];
			st_next.ipf = wdata_i[`FBIU_IPF_BIT];
			st_next.pf_limit = wdata_i[`FBIU_PF_LIMIT_LSB +: 2];
			st_next.lbuf = wdata_i[`FBIU_LBUF_BIT];
		end
		if (wr_i && addr_i == `FBIU_CTRL_OFS)
		begin
			st_next.rd_dis = wdata_i[`FBIU_RDIS_BIT];
		end
		// Status write-one-to-clear; a same-cycle event still sets below
		if (wr_i && addr_i == `FBIU_STAT_OFS)
		begin
			st_next.done = st_reg.done & ~wdata_i[`FBIU_DONE_BIT];
			st_next.tmo = st_reg.tmo & ~wdata_i[`FBIU_TMO_BIT];
		end
		case (st_reg.phase)
			fbiu_pkg::st_idle:
			begin
				// A start while busy is dropped; the clock is assumed fast enough
				if (wr_i && addr_i == `FBIU_CTRL_OFS && wdata_i[`FBIU_PGO_BIT])
				begin
					st_next.phase = fbiu_pkg::st_prog;
					st_next.page_mode = wdata_i[`FBIU_PAGE_BIT];
					st_next.cnt = 30'h0;
				end
				else if (wr_i && addr_i == `FBIU_CTRL_OFS && wdata_i[`FBIU_EGO_BIT])
				begin
					st_next.phase = fbiu_pkg::st_erase;
					st_next.blk = wdata_i[`FBIU_BLK_LSB +: 2];
					st_next.cnt = 30'h0;
				end
			end
			fbiu_pkg::st_prog, fbiu_pkg::st_erase:
			begin
				if (fl_done_i)
				begin
					st_next.phase = fbiu_pkg::st_idle;
					st_next.done = 1'b1;
				end
				else if (st_reg.cnt == cur_limit - 30'h1)
				begin
					// Abandon after the worst case time has passed
					st_next.phase = fbiu_pkg::st_idle;
					st_next.done = 1'b1;
					st_next.tmo = 1'b1;
				end
			end
			default:
			begin
				st_next.phase = fbiu_pkg::st_idle;
			end
		endcase
		if (rd_i)
		begin
			case (addr_i)
				`FBIU_CFG_OFS:
				begin
					st_next.rdata[`FBIU_PIPE_LSB +: 3] = st_reg.pipe;
					st_next.rdata[`FBIU_RWAIT_LSB +: 3] = st_reg.rwait;
					st_next.rdata[`FBIU_WWSC_LSB +: 2] = st_reg.wwsc;
					st_next.rdata[`FBIU_DPF_BIT] = st_reg.dpf;
					st_next.rdata[`FBIU_IPF_BIT] = st_reg.ipf;
					st_next.rdata[`FBIU_PF_LIMIT_LSB +: 2] = st_reg.pf_limit;
					st_next.rdata[`FBIU_LBUF_BIT] = st_reg.lbuf;
				end
				`FBIU_CTRL_OFS:
				begin
					st_next.rdata[`FBIU_RDIS_BIT] = st_reg.rd_dis;
					st_next.rdata[`FBIU_PAGE_BIT] = st_reg.page_mode;
					st_next.rdata[`FBIU_BLK_LSB +: 2] = st_reg.blk;
				end
				`FBIU_STAT_OFS:
				begin
					st_next.rdata[`FBIU_BUSY_BIT] = busy;
					st_next.rdata[`FBIU_DONE_BIT] = st_reg.done;
					st_next.rdata[`FBIU_TMO_BIT] = st_reg.tmo;
					st_next.rdata[`FBIU_ILL_BIT] = ~legal;
				end
				default:
				begin
					// Page words come from the store; other addresses read zero
					st_next.rd_mem = (addr_i[7:4] == `FBIU_DATA_OFS >> 4);
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_reg <= ST_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign rdata_o = st_reg.rd_mem ? mem_bus.rd_data : st_reg.rdata;
	assign address_pipeline_control_o = st_reg.pipe;
	assign read_wait_state_count_o = st_reg.rwait;
	assign write_wait_state_count_o = st_reg.wwsc;
	assign data_prefetch_enable_o = st_reg.dpf;
	assign instruction_prefetch_enable_o = st_reg.ipf;
	assign prefetch_limit_o = st_reg.pf_limit;
	assign line_buffer_enable_o = st_reg.lbuf;
	assign pipelined_read_disable_o = st_reg.rd_dis;
	assign fl_prog_o = (st_reg.phase == fbiu_pkg::st_prog);
	assign fl_erase_o = (st_reg.phase == fbiu_pkg::st_erase);
	assign fl_page_mode_o = st_reg.page_mode;
	assign fl_block_o = st_reg.blk;
	assign fl_data_o = mem_bus.page;
	assign busy_o = busy;
	assign illegal_cfg_o = ~legal;

	// Helper: high during reset and in the first cycle after reset release
	logic first_reg;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			first_reg <= 1'b1;
		end
		else
		begin
			first_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	reset_values_a: assert property (
		first_reg |-> address_pipeline_control_o == 3'h7 && read_wait_state_count_o == 3'h7
			&& write_wait_state_count_o == 2'h3 && !data_prefetch_enable_o
			&& !instruction_prefetch_enable_o && prefetch_limit_o == 2'h0
			&& !line_buffer_enable_o && illegal_cfg_o)
		else $error("settings not at reset values");

	cfg_apply_a: assert property (
		(wr_i && addr_i == `FBIU_CFG_OFS) |=> read_wait_state_count_o ==
			$past(wdata_i[`FBIU_RWAIT_LSB +: 3]) && prefetch_limit_o ==
			$past(wdata_i[`FBIU_PF_LIMIT_LSB +: 2]))
		else $error("settings write not applied");

	prog_bound_a: assert property (
		fl_prog_o |-> st_reg.cnt < PROG_MAX_CYC)
		else $error("program ran past its limit");

	erase_limit_a: assert property (
		fl_erase_o |-> cur_limit == ((fl_block_o == 2'h3) ? ERASE128_MAX_CYC : ERASE_MAX_CYC))
		else $error("erase limit wrong for block size");

	timeout_end_a: assert property (
		(busy && !fl_done_i && st_reg.cnt == cur_limit - 30'h1) |=> !busy_o && st_reg.tmo
			&& st_reg.done)
		else $error("timeout not reported");

	page_stable_a: assert property (
		(busy && $past(busy)) |-> $stable(fl_data_o))
		else $error("page data changed during an operation");

	dword_mode_a: assert property (
		(wr_i && addr_i == `FBIU_CTRL_OFS && wdata_i[`FBIU_PGO_BIT] && !busy
			&& !wdata_i[`FBIU_PAGE_BIT]) |=> fl_prog_o && !fl_page_mode_o)
		else $error("double word program not started");

	done_end_a: assert property (
		(busy && fl_done_i) |=> !busy_o && st_reg.done && !$past(st_reg.tmo) == !st_reg.tmo)
		else $error("completion not taken");

	legal_row_a: assert property (
		(!illegal_cfg_o && address_pipeline_control_o == 3'h0) |-> pipelined_read_disable_o
			&& write_wait_state_count_o == 2'h1)
		else $error("zero wait row accepted without read disable");

	prog_done_c: cover property (fl_prog_o ##1 !fl_prog_o && st_reg.done && !st_reg.tmo);
	erase_tmo_c: cover property (fl_erase_o ##1 !fl_erase_o && st_reg.tmo);
	legal_cfg_c: cover property ($fell(illegal_cfg_o));

endmodule : fbiu_top

//--- shared/fbiu_cfg.svh
// Offsets, field positions, reset values and timing figures of the flash bus interface unit
`ifndef FBIU_CFG_SVH
`define FBIU_CFG_SVH

// Register byte offsets
`define FBIU_CFG_OFS 8'h00
`define FBIU_CTRL_OFS 8'h04
`define FBIU_STAT_OFS 8'h08
`define FBIU_DATA_OFS 8'h10

// Interface settings register fields
`define FBIU_PIPE_LSB 0
`define FBIU_RWAIT_LSB 4
`define FBIU_WWSC_LSB 8
`define FBIU_DPF_BIT 12
`define FBIU_IPF_BIT 13
`define FBIU_PF_LIMIT_LSB 16
`define FBIU_LBUF_BIT 20

// Module config register fields
`define FBIU_RDIS_BIT 0
`define FBIU_PGO_BIT 4
`define FBIU_EGO_BIT 5
`define FBIU_PAGE_BIT 8
`define FBIU_BLK_LSB 12

// Status register fields
`define FBIU_BUSY_BIT 0
`define FBIU_DONE_BIT 1
`define FBIU_TMO_BIT 2
`define FBIU_ILL_BIT 3

// Reset values
`define FBIU_PIPE_RST 3'h7
`define FBIU_RWAIT_RST 3'h7
`define FBIU_WWSC_RST 2'h3
`define FBIU_PF_LIMIT_RST 2'h0

// Legal settings rows and the 128 Kbyte block code
`define FBIU_ROW_MAX 3'h3
`define FBIU_WWSC_ROW 2'h1
`define FBIU_BLK_128K 2'h3

// Timing figures
`define FBIU_CLK_KHZ 40000
`define FBIU_PROG_MAX_US 500
`define FBIU_ERASE_MAX_MS 5000
`define FBIU_ERASE128_MAX_MS 15000

`endif

//--- shared/fbiu_mem_if.sv
// Carrier between the controller and its program page store
`timescale 1ns/1ps
interface fbiu_mem_if;
	logic wr;
	logic [1:0] wr_idx;
	logic [31:0] wr_data;
	logic [1:0] rd_idx;
	logic [31:0] rd_data;
	logic [127:0] page;

	modport ctrl (output wr, output wr_idx, output wr_data, output rd_idx,
		input rd_data, input page);
	modport mem (input wr, input wr_idx, input wr_data, input rd_idx,
		output rd_data, output page);
endinterface : fbiu_mem_if

//--- shared/fbiu_pkg.sv
// Types of the flash bus interface unit
package fbiu_pkg;

	typedef enum logic [1:0] {st_idle, st_prog, st_erase} fbiu_phase_t;

	typedef struct packed {
		logic [2:0] pipe;
		logic [2:0] rwait;
		logic [1:0] wwsc;
		logic dpf;
		logic ipf;
		logic [1:0] pf_limit;
		logic lbuf;
		logic rd_dis;
		fbiu_phase_t phase;
		logic page_mode;
		logic [1:0] blk;
		logic [29:0] cnt;
		logic done;
		logic tmo;
		logic [31:0] rdata;
		logic rd_mem;
	} fbiu_state_t;

	typedef struct packed {
		logic [3:0][31:0] word;
		logic [31:0] rd;
	} fbiu_mem_state_t;

endpackage : fbiu_pkg

//--- tb/fbiu_flash_model.sv
// Flash array stand-in that answers program and erase requests
`timescale 1ns/1ps
module fbiu_flash_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic fl_prog_i,
	input wire logic fl_erase_i,
	input wire logic [7:0] delay_i,
	output logic fl_done_o
);
	logic [7:0] cnt_reg;
	// One-cycle done after delay_i busy cycles; zero never answers, forcing a timeout
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cnt_reg <= 8'h00;
			fl_done_o <= 1'b0;
		end
		else
		begin
			fl_done_o <= 1'b0;
			if (fl_prog_i || fl_erase_i)
			begin
				cnt_reg <= cnt_reg + 8'h01;
				if (delay_i != 8'h00 && cnt_reg == delay_i - 8'h01)
					fl_done_o <= 1'b1;
			end
			else
				cnt_reg <= 8'h00;
		end
	end
endmodule : fbiu_flash_model

//--- tb/tb_top.sv
// Self-checking bench of the flash bus interface unit
`timescale 1ns/1ps
`include "fbiu_cfg.svh"
module tb_top;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] fl_delay = 8'h07;
	logic fl_done;
	logic [31:0] rdata;
	logic [2:0] pipe_q, rwait_q;
	logic [1:0] wwait_q, lim_q, blk_q;
	logic dpf_q, ipf_q, lbuf_q, rdis_q, prog_q, erase_q, page_q, busy_q, ill_q;
	logic [127:0] fl_data;
	logic [31:0] seed = 32'h0000_0030;
	logic [31:0] m_cfg, d, pg [4];
	logic m_dis = 1'b0;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	int b;
	int lims [4] = '{20, 40, 60, 0};

	fbiu_top #(.PROG_MAX_CYC(30'd20), .ERASE_MAX_CYC(30'd40),
		.ERASE128_MAX_CYC(30'd60)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
		.address_pipeline_control_o(pipe_q), .read_wait_state_count_o(rwait_q),
		.write_wait_state_count_o(wwait_q), .data_prefetch_enable_o(dpf_q),
		.instruction_prefetch_enable_o(ipf_q), .prefetch_limit_o(lim_q),
		.line_buffer_enable_o(lbuf_q), .pipelined_read_disable_o(rdis_q),
		.fl_prog_o(prog_q), .fl_erase_o(erase_q), .fl_page_mode_o(page_q),
		.fl_block_o(blk_q), .fl_data_o(fl_data), .fl_done_i(fl_done),
		.busy_o(busy_q), .illegal_cfg_o(ill_q));

	fbiu_flash_model flash (.clk_i(clk_i), .nrst_i(nrst_i), .fl_prog_i(prog_q),
		.fl_erase_i(erase_q), .delay_i(fl_delay), .fl_done_o(fl_done));

	// 40 MHz keeps program and erase above their minimum clock
	initial
	begin
		forever #12.5 clk_i = ~clk_i;
	end

	// Hang guard: far above the few hundred cycles the tests need
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			wrap_up();
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Settings fields packed in port order
	function automatic logic [12:0] sv_of(input logic [31:0] c);
		return {c[2:0], c[6:4], c[9:8], c[12], c[13], c[17:16], c[20]};
	endfunction : sv_of

	function automatic logic ill_of(input logic [31:0] c, input logic p);
		return !(c[2:0] == c[6:4] && c[2:0] <= 3'h3 && c[9:8] == 2'h1 && (c[2:0] != 0 || p));
	endfunction : ill_of

	task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata;
	endtask : rd

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	initial
	begin
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		#1;
		m_cfg = 32'h0000_0377;
		chk("rst set", {pipe_q, rwait_q, wwait_q, dpf_q, ipf_q, lim_q, lbuf_q}, sv_of(m_cfg));
		chk("rst ill", ill_q, 1'b1);
		rd(`FBIU_CFG_OFS, d);
		chk("rst cfg", d, m_cfg);
		$display("test reset done");
		// Zero-wait row without the disable bit, three legal rows, one mixed row, then the zero-wait row with the disable bit
		for (int r = 0; r < 6; r++)
		begin
			if (r == 5)
			begin
				m_dis = 1'b1;
				wr(`FBIU_CTRL_OFS, 32'h0000_0001);
			end
			d = (r < 4) ? 32'(r * 17) : (r == 4 ? 32'h0000_0021 : 32'h0000_0000);
			m_cfg = d | 32'h0000_0100 | (xs() & 32'h0013_3000);
			wr(`FBIU_CFG_OFS, m_cfg);
			chk("set", {pipe_q, rwait_q, wwait_q, dpf_q, ipf_q, lim_q, lbuf_q}, sv_of(m_cfg));
			chk("ill", ill_q, ill_of(m_cfg, m_dis));
			chk("dis", rdis_q, m_dis);
			rd(`FBIU_CFG_OFS, d);
			chk("cfg rd", d, m_cfg);
		end
		rd(8'h0C, d);
		chk("unmapped", d, 32'h0000_0000);
		$display("test settings done");
		// Page then double word, answered by the flash
		for (int p = 1; p >= 0; p--)
		begin
			for (int i = 0; i < 4; i++)
			begin
				pg[i] = xs();
				wr(8'(`FBIU_DATA_OFS + 4 * i), pg[i]);
			end
			wr(`FBIU_CTRL_OFS, {23'h0, 1'(p), 7'h08, m_dis});
			chk("prog", {prog_q, busy_q, page_q}, {2'b11, 1'(p)});
			wr(`FBIU_DATA_OFS, ~pg[0]);
			chk("page", fl_data, {pg[3], pg[2], pg[1], pg[0]});
			n = 0;
			while (busy_q === 1'b1 && n < 100)
			begin
				n++;
				@(posedge clk_i);
				#1;
			end
			rd(`FBIU_STAT_OFS, d);
			chk("stat", d[3:0], {ill_of(m_cfg, m_dis), 3'b010});
			wr(`FBIU_STAT_OFS, 32'h0000_0002);
			rd(8'(`FBIU_DATA_OFS + 12), d);
			chk("word rd", d, pg[3]);
		end
		$display("test program done");
		// Silent flash: timeouts at each limit, then an answered erase
		for (int k = 0; k < 4; k++)
		begin
			fl_delay <= (k == 3) ? 8'h05 : 8'h00;
			// Block codes 1, 3, 2, so the 128 Kbyte limit is reached as well
			b = k ^ (k >> 1);
			d = (k == 0) ? 32'h0000_0010 : 32'h0000_0020 | 32'(b) << 12;
			wr(`FBIU_CTRL_OFS, d | 32'(m_dis));
			if (k > 0)
				chk("blk", {erase_q, blk_q}, {1'b1, 2'(b)});
			n = 0;
			while (busy_q === 1'b1 && n < 100)
			begin
				n++;
				@(posedge clk_i);
				#1;
			end
			if (k < 3)
				chk("limit", n, lims[k]);
			rd(`FBIU_CTRL_OFS, d);
			chk("ctrl rd", d, 32'(b) << 12 | 32'(m_dis));
			rd(`FBIU_STAT_OFS, d);
			chk("tmo", d[3:0], {ill_of(m_cfg, m_dis), (k < 3), 2'b10});
			wr(`FBIU_STAT_OFS, 32'h0000_0006);
		end
		rd(`FBIU_STAT_OFS, d);
		chk("clr", d[2:0], 3'b000);
		$display("test timeout done");
		wrap_up();
	end
endmodule : tb_top
